// ---- rtl/dphy_timing_pkg.sv ----
`default_nettype none
package dphy_timing_pkg;

    // ----------------------------------------------------------------
    // Bus geometry and register indices (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned TIMING_COUNT = 5;
    localparam int unsigned VALUE_W = 7;
    localparam int unsigned OVERRIDE_BIT = 7;
    localparam int unsigned WE_LANE = 0;
    localparam logic [7:0] CLK_PREPARE_IDX = 8'h40;
    localparam logic [7:0] CLK_ZERO_IDX = 8'h41;
    localparam logic [7:0] CLK_TRAIL_IDX = 8'h42;
    localparam logic [7:0] CLK_POST_IDX = 8'h43;
    localparam logic [7:0] DATA_PREPARE_IDX = 8'h44;
    localparam logic [7:0] LANE_RATE_IDX = 8'h30;
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef logic [TIMING_COUNT-1:0][VALUE_W-1:0] interval_vec_t;

    typedef struct packed {
        logic [6:0] data_prepare;
        logic [6:0] clk_post;
        logic [6:0] clk_trail;
        logic [6:0] clk_zero;
        logic [6:0] clk_prepare;
    } timing_set_t;

    typedef enum logic [2:0] {
        RATE_400 = 3'h0,
        RATE_800 = 3'h1,
        RATE_1200 = 3'h2,
        RATE_1500 = 3'h3,
        RATE_1600 = 3'h4
    } lane_rate_t;

    // ----------------------------------------------------------------
    // Reset values and rate table
    // ----------------------------------------------------------------
    localparam int unsigned REF_RATE_MBPS = 800;
    localparam logic [2:0] RATE_CODE_MAX = 3'h4;
    localparam logic [6:0] VALUE_MAX = 7'h7f;
    localparam logic [6:0] RST_CLK_PREPARE = 7'h05;
    localparam logic [6:0] RST_CLK_ZERO = 7'h1b;
    localparam logic [6:0] RST_CLK_TRAIL = 7'h0b;
    localparam logic [6:0] RST_CLK_POST = 7'h0a;
    localparam logic [6:0] RST_DATA_PREPARE = 7'h06;
    localparam logic [4:0] RST_OVERRIDE = 5'h00;
    localparam lane_rate_t RST_LANE_RATE = RATE_800;
    localparam interval_vec_t INTERVAL_800 = {RST_DATA_PREPARE, RST_CLK_POST,
        RST_CLK_TRAIL, RST_CLK_ZERO, RST_CLK_PREPARE};

    function automatic int unsigned rate_mbps(input lane_rate_t r);
        case (r)
            RATE_400: return 400;
            RATE_1200: return 1200;
            RATE_1500: return 1500;
            RATE_1600: return 1600;
            default: return REF_RATE_MBPS;
        endcase
    endfunction

    // Intervals count in byte-clock units, so they scale with lane rate
    function automatic logic [6:0] scale_interval(input logic [6:0] base,
                                                 input lane_rate_t r);
        int unsigned prod;
        prod = (int'(base) * rate_mbps(r) + REF_RATE_MBPS - 1) / REF_RATE_MBPS;
        if (prod > int'(VALUE_MAX)) begin
            return VALUE_MAX;
        end
        return prod[6:0];
    endfunction

    // ----------------------------------------------------------------
    // Register bank state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [TIMING_COUNT-1:0] sel;
        interval_vec_t val;
        timing_set_t applied;
        lane_rate_t rate;
        logic waitreq;
        logic [DATA_W-1:0] rdata;
    } regs_state_t;

    localparam regs_state_t REGS_RESET = '{
        sel: RST_OVERRIDE,
        val: INTERVAL_800,
        applied: timing_set_t'(INTERVAL_800),
        rate: RST_LANE_RATE,
        waitreq: 1'b1,
        rdata: 32'h0
    };

endpackage
`default_nettype wire

// ---- rtl/dphy_timing_auto.sv ----
`default_nettype none
module dphy_timing_auto (
    input wire dphy_timing_pkg::lane_rate_t rate_i,
    output var dphy_timing_pkg::interval_vec_t auto_o
);

    // ----------------------------------------------------------------
    // Automatic interval per lane rate
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < dphy_timing_pkg::TIMING_COUNT; g++) begin : g_auto
            assign auto_o[g] = dphy_timing_pkg::scale_interval(
                dphy_timing_pkg::INTERVAL_800[g], rate_i);
        end
    endgenerate

endmodule
`default_nettype wire

// ---- rtl/dphy_timing_override_regs.sv ----
// Notes on behaviour
// - Clock-prepare override bit clear selects auto interval, set selects stored value.
// - Clock-zero override bit clear selects auto interval, set selects stored value.
// - Clock-trail override bit clear selects auto interval, set selects stored value.
// - Clock-post override bit clear selects auto interval, set selects stored value.
// - Data-prepare override bit clear selects auto interval, set selects stored value.
// - With override clear, value field ignores writes and reads the auto interval.
// - With override set, value field takes writes and reads back stored value.
// - Auto intervals default to 800 Mbps and follow the selected lane rate.
// - Reset values: clock prepare 0x5, clock zero 0x1B, clock trail 0x0B.
// - Reset values: clock post 0x0A, data prepare 0x6.
// - All override bits reset to zero, so every interval starts automatic.
`default_nettype none
module dphy_timing_override_regs (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic [dphy_timing_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [dphy_timing_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [dphy_timing_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output var dphy_timing_pkg::timing_set_t timing_o,
    output var dphy_timing_pkg::lane_rate_t lane_rate_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    dphy_timing_pkg::regs_state_t st_ff;
    dphy_timing_pkg::regs_state_t nxt_st;
    dphy_timing_pkg::interval_vec_t auto_v;
    dphy_timing_pkg::interval_vec_t applied_v;
    logic [dphy_timing_pkg::DATA_W-1:0] rd_word;
    logic [7:0] idx;
    logic [2:0] slot;
    logic req;
    logic take;
    logic wr_take;
    logic hit_timing;
    logic hit_rate;
    logic aligned;
    logic rate_ok;

    // ----------------------------------------------------------------
    // Automatic interval derivation
    // ----------------------------------------------------------------
    dphy_timing_auto u_auto (
        .rate_i (st_ff.rate),
        .auto_o (auto_v)
    );

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    assign req = avs_read_i | avs_write_i;
    // A request completes on the edge where waitrequest is seen low
    assign take = req & ~st_ff.waitreq;
    assign wr_take = take & avs_write_i & avs_byteenable_i[dphy_timing_pkg::WE_LANE];
    assign idx = avs_address_i[9:2];
    assign aligned = (avs_address_i[1:0] == dphy_timing_pkg::WORD_ALIGN);
    assign hit_timing = aligned && (idx >= dphy_timing_pkg::CLK_PREPARE_IDX)
        && (idx <= dphy_timing_pkg::DATA_PREPARE_IDX);
    assign hit_rate = aligned && (idx == dphy_timing_pkg::LANE_RATE_IDX);
    assign slot = 3'(idx - dphy_timing_pkg::CLK_PREPARE_IDX);
    assign rate_ok = (avs_writedata_i[2:0] <= dphy_timing_pkg::RATE_CODE_MAX);

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    always_comb begin
        rd_word = 32'h0;
        if (hit_timing) begin
            if (st_ff.sel[slot]) begin
                rd_word = {24'h0, 1'b1, st_ff.val[slot]};
            end else begin
                rd_word = {24'h0, 1'b0, auto_v[slot]};
            end
        end else if (hit_rate) begin
            rd_word = {29'h0, st_ff.rate};
        end
    end

    // ----------------------------------------------------------------
    // Interval source select, one per interval
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < dphy_timing_pkg::TIMING_COUNT; g++) begin : g_sel
            assign applied_v[g] = st_ff.sel[g] ? st_ff.val[g] : auto_v[g];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.waitreq = 1'b1;
        if (req && st_ff.waitreq) begin
            nxt_st.waitreq = 1'b0;
            nxt_st.rdata = rd_word;
        end
        if (wr_take && hit_timing) begin
            nxt_st.sel[slot] = avs_writedata_i[dphy_timing_pkg::OVERRIDE_BIT];
            if (avs_writedata_i[dphy_timing_pkg::OVERRIDE_BIT]) begin
                nxt_st.val[slot] = avs_writedata_i[6:0];
            end
        end else if (wr_take && hit_rate && rate_ok) begin
            nxt_st.rate = dphy_timing_pkg::lane_rate_t'(avs_writedata_i[2:0]);
        end
        nxt_st.applied = dphy_timing_pkg::timing_set_t'(applied_v);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            st_ff <= dphy_timing_pkg::REGS_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign avs_readdata_o = st_ff.rdata;
    assign avs_waitrequest_o = st_ff.waitreq;
    assign timing_o = st_ff.applied;
    assign lane_rate_o = st_ff.rate;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    prep_select_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        1'b1 |=> timing_o.clk_prepare ==
            ($past(st_ff.sel[0]) ? $past(st_ff.val[0]) : $past(auto_v[0])))
        else $error("clock prepare interval not from selected source");

    zero_select_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        1'b1 |=> timing_o.clk_zero ==
            ($past(st_ff.sel[1]) ? $past(st_ff.val[1]) : $past(auto_v[1])))
        else $error("clock zero interval not from selected source");

    trail_select_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        1'b1 |=> timing_o.clk_trail ==
            ($past(st_ff.sel[2]) ? $past(st_ff.val[2]) : $past(auto_v[2])))
        else $error("clock trail interval not from selected source");

    post_select_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        1'b1 |=> timing_o.clk_post ==
            ($past(st_ff.sel[3]) ? $past(st_ff.val[3]) : $past(auto_v[3])))
        else $error("clock post interval not from selected source");

    dprep_select_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        1'b1 |=> timing_o.data_prepare ==
            ($past(st_ff.sel[4]) ? $past(st_ff.val[4]) : $past(auto_v[4])))
        else $error("data prepare interval not from selected source");

    auto_write_ignore_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_take && hit_timing && !avs_writedata_i[7] |=> $stable(st_ff.val))
        else $error("value field changed by write with override clear");

    auto_read_back_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        take && avs_read_i && hit_timing && !st_ff.sel[slot]
            |-> avs_readdata_o == {24'h0, 1'b0, $past(auto_v[slot])})
        else $error("automatic field read does not show derived interval");

    manual_write_store_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_take && hit_timing && avs_writedata_i[7]
            |=> st_ff.sel[$past(slot)]
            && st_ff.val[$past(slot)] == $past(avs_writedata_i[6:0]))
        else $error("override write did not store value");

    rate_derive_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st_ff.rate == dphy_timing_pkg::RATE_1600
            |-> auto_v[1] == 7'(2 * dphy_timing_pkg::RST_CLK_ZERO))
        else $error("clock zero not rescaled for the faster lane rate");

    reset_clock_vals_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $past(!rstn_i) |-> st_ff.val[0] == 7'h05 && st_ff.val[1] == 7'h1b
            && st_ff.val[2] == 7'h0b && auto_v[1] == 7'h1b)
        else $error("clock prepare, zero or trail reset value wrong");

    reset_post_data_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $past(!rstn_i) |-> st_ff.val[3] == 7'h0a && st_ff.val[4] == 7'h06
            && timing_o.clk_post == 7'h0a && timing_o.data_prepare == 7'h06)
        else $error("clock post or data prepare reset value wrong");

    reset_auto_mode_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $past(!rstn_i) |-> st_ff.sel == 5'h00 && lane_rate_o == dphy_timing_pkg::RATE_800)
        else $error("override bits not clear after reset");

    // ----------------------------------------------------------------
    // Bus handshake and field access checks
    // ----------------------------------------------------------------

    wait_answer_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered in the next cycle");

    wait_one_cycle_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");

    wait_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !req |=> avs_waitrequest_o)
        else $error("waitrequest low without a request");

    idle_readdata_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !req |=> $stable(avs_readdata_o))
        else $error("read data changed while idle");

    readdata_upper_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");

    unmapped_read_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        take && avs_read_i && !hit_timing && !hit_rate |-> avs_readdata_o == 32'h0)
        else $error("unmapped read returned nonzero data");

    manual_read_back_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        take && avs_read_i && hit_timing && st_ff.sel[slot]
            |-> avs_readdata_o == {24'h0, 1'b1, st_ff.val[slot]})
        else $error("manual field read does not show stored value");

    override_clear_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_take && hit_timing && !avs_writedata_i[7] |=> !st_ff.sel[$past(slot)])
        else $error("write with bit 7 clear left override set");

    byte_lane_ignore_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        take && avs_write_i && !avs_byteenable_i[0]
            |=> $stable(st_ff.sel) && $stable(st_ff.val) && $stable(lane_rate_o))
        else $error("write without low byte enable changed a register");

    misaligned_ignore_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        take && avs_write_i && !aligned |=> $stable(st_ff.sel) && $stable(st_ff.val))
        else $error("misaligned write changed a timing register");

    sel_write_only_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !wr_take |=> $stable(st_ff.sel))
        else $error("override bits changed without a write");

    val_write_only_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !(wr_take && hit_timing && avs_writedata_i[7]) |=> $stable(st_ff.val))
        else $error("stored value changed without an override write");

    rate_write_only_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !(wr_take && hit_rate) |=> $stable(lane_rate_o))
        else $error("lane rate changed without a write");

    rate_write_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_take && hit_rate && rate_ok |=> lane_rate_o == $past(avs_writedata_i[2:0]))
        else $error("lane rate write not taken");

    rate_refuse_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_take && hit_rate && !rate_ok |=> $stable(lane_rate_o))
        else $error("out of range lane rate code taken");

    rate_read_back_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        take && avs_read_i && hit_rate |-> avs_readdata_o == {29'h0, lane_rate_o})
        else $error("lane rate read back wrong");

    auto_default_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st_ff.rate == dphy_timing_pkg::RATE_800
            |-> auto_v == dphy_timing_pkg::INTERVAL_800)
        else $error("automatic intervals differ from defaults at the reference rate");

    auto_slow_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st_ff.rate == dphy_timing_pkg::RATE_400 |-> auto_v[1] == 7'h0e)
        else $error("clock zero not rescaled for the slowest lane rate");

    auto_mid_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st_ff.rate == dphy_timing_pkg::RATE_1200 |-> auto_v[0] == 7'h08)
        else $error("clock prepare not rescaled for the middle lane rate");

    auto_fast_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st_ff.rate == dphy_timing_pkg::RATE_1500 |-> auto_v[2] == 7'h15)
        else $error("clock trail not rescaled for the fast lane rate");

    timing_lag_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        1'b1 |=> timing_o == dphy_timing_pkg::timing_set_t'($past(applied_v)))
        else $error("applied intervals not registered from the selection");

endmodule
`default_nettype wire

// ---- sim/tb_dphy_timing_override_regs.sv ----
`default_nettype none
module tb_dphy_timing_override_regs;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and reference model state
    // ------------------------------------------------------------
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [9:0] avs_address_i = 10'h000;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    dphy_timing_pkg::timing_set_t timing_o;
    dphy_timing_pkg::lane_rate_t lane_rate_o;
    int failures = 0;
    int check_count = 0;
    integer seed = 32'h9f35b093;
    int sel[5];
    int val[5];
    int rate;
    int base[5] = '{5, 27, 11, 10, 6};
    int mbps[5] = '{400, 800, 1200, 1500, 1600};
    logic [9:0] addrs[8] = '{10'h100, 10'h104, 10'h108, 10'h10c, 10'h110, 10'h0c0, 10'h102,
        10'h200};
    logic [31:0] rd;
    logic [31:0] d;
    logic [9:0] a;

    always #10 ref_clk_i = ~ref_clk_i;

    dphy_timing_override_regs dphy_timing_override_regs_inst (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .timing_o(timing_o),
        .lane_rate_o(lane_rate_o)
    );

    // ------------------------------------------------------------
    // Model
    // ------------------------------------------------------------
    task automatic model_reset();
        for (int i = 0; i < 5; i++) begin
            sel[i] = 0;
            val[i] = base[i];
        end
        rate = 1;
    endtask

    function automatic int exp_field(int i);
        int p;
        p = (base[i] * mbps[rate] + 799) / 800;
        if (p > 127) begin
            p = 127;
        end
        return (sel[i] != 0) ? val[i] : p;
    endfunction

    function automatic logic [31:0] exp_read(logic [9:0] ad);
        int i;
        i = int'(ad[9:2]) - 64;
        if (ad[1:0] != 2'h0) begin
            return 32'h00000000;
        end
        if (ad[9:2] == 8'h30) begin
            return 32'(rate);
        end
        if (i >= 0 && i < 5) begin
            return 32'(sel[i] * 128 + exp_field(i));
        end
        return 32'h00000000;
    endfunction

    task automatic model_write(logic [9:0] ad, logic [31:0] wd, logic [3:0] be);
        int i;
        i = int'(ad[9:2]) - 64;
        if (be[0] && ad[1:0] == 2'h0) begin
            if (i >= 0 && i < 5) begin
                sel[i] = wd[7];
                if (wd[7]) begin
                    val[i] = wd[6:0];
                end
            end else if (ad[9:2] == 8'h30 && wd[2:0] <= 3'h4) begin
                rate = wd[2:0];
            end
        end
    endtask

    // ------------------------------------------------------------
    // Bus access and checks
    // ------------------------------------------------------------
    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic bus(logic wr, logic [9:0] ad, logic [31:0] wd, logic [3:0] be);
        int n;
        @(posedge ref_clk_i);
        avs_address_i <= ad;
        avs_writedata_i <= wd;
        avs_byteenable_i <= be;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        if (avs_waitrequest_o !== 1'b0) begin
            failures++;
            $display("[FAIL] waitrequest expected 0 seen %b", avs_waitrequest_o);
            conclude();
        end else begin
            rd = avs_readdata_o;
            avs_write_i <= 1'b0;
            avs_read_i <= 1'b0;
            if (wr) begin
                model_write(ad, wd, be);
            end else begin
                chk("readdata", exp_read(ad), rd);
            end
        end
    endtask

    task automatic out_chk();
        repeat (2) @(posedge ref_clk_i);
        #1;
        for (int i = 0; i < 5; i++) begin
            chk("timing field", 32'(exp_field(i)), 32'(timing_o[i*7 +: 7]));
        end
        chk("lane rate", 32'(rate), 32'(lane_rate_o));
    endtask

    task automatic all_chk();
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, addrs[i], 32'h00000000, 4'hf);
        end
        out_chk();
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        model_reset();
        repeat (10) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        all_chk();
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, addrs[i], 32'h0000007f, 4'hf);
        end
        all_chk();
        $display("test auto field done");
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, addrs[i], 32'h80 | ($random(seed) & 32'h7f), 4'hf);
        end
        all_chk();
        bus(1'b1, addrs[0], 32'h00000000, 4'he);
        bus(1'b1, 10'h101, 32'h00000000, 4'hf);
        bus(1'b0, 10'h3fc, 32'h00000000, 4'hf);
        all_chk();
        $display("test override done");
        bus(1'b1, addrs[0], 32'h00000000, 4'hf);
        bus(1'b1, addrs[2], 32'h00000000, 4'hf);
        for (int r = 0; r < 6; r++) begin
            bus(1'b1, 10'h0c0, 32'(r), 4'hf);
            all_chk();
        end
        $display("test lane rate done");
        repeat (40) begin
            a = addrs[$unsigned($random(seed)) % 8];
            d = $random(seed);
            if (a == 10'h0c0) begin
                d = d & 32'h0000000f;
            end
            bus(1'($random(seed)), a, d, 4'($random(seed)));
            out_chk();
        end
        $display("test random traffic done");
        @(posedge ref_clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        model_reset();
        all_chk();
        $display("test second reset done");
        conclude();
    end
endmodule
`default_nettype wire
